//--- ied_pkg.sv
// constants and types of the input event and diagnostic block
// assumes a 25 MHz clock and loop currents given in microamps
// ====================================================================
package ied_pkg;
	localparam int CH_NUM = 4;
	localparam int CUR_W = 16;
	localparam int CNT_W = 19;
	localparam int MASK_W = 32;
	localparam int CLK_MHZ = 25;
	localparam logic [15:0] SHORT_UA = 16'h2134;
	localparam logic [15:0] OPEN_UA = 16'h0064;
	localparam int DLY_0P1_US = 100;
	localparam int DLY_0P5_US = 500;
	localparam int DLY_3_US = 3000;
	localparam int DLY_15_US = 15000;
	localparam int DLY_20_US = 20000;
	localparam int SUPPLY_HOLD_US = 20000;
	localparam int DLY_0P1_CYC = DLY_0P1_US * CLK_MHZ;
	localparam int DLY_0P5_CYC = DLY_0P5_US * CLK_MHZ;
	localparam int DLY_3_CYC = DLY_3_US * CLK_MHZ;
	localparam int DLY_15_CYC = DLY_15_US * CLK_MHZ;
	localparam int DLY_20_CYC = DLY_20_US * CLK_MHZ;
	localparam int SUPPLY_HOLD_CYC = SUPPLY_HOLD_US * CLK_MHZ;
	typedef enum logic [2:0] {
		IED_DLY_0P1,
		IED_DLY_0P5,
		IED_DLY_3,
		IED_DLY_15,
		IED_DLY_20
	} ied_dly_type;
endpackage : ied_pkg

//--- ied_top.sv
// input filtering, fault classification, process events and supply handling
// assumes all inputs synchronous to ref_clk; host acknowledges with ack_strobe
`timescale 1ns/1ps
`default_nettype none
module ied_top
	import ied_pkg::*;
#(
	parameter int DLY_0P5_CYC_P = DLY_0P5_CYC,
	parameter int DLY_3_CYC_P = DLY_3_CYC,
	parameter int DLY_15_CYC_P = DLY_15_CYC,
	parameter int DLY_20_CYC_P = DLY_20_CYC,
	parameter int SUPPLY_HOLD_CYC_P = SUPPLY_HOLD_CYC
) (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic [CH_NUM-1:0] raw_in,
	input wire logic [CH_NUM-1:0][CUR_W-1:0] loop_current_ua,
	input wire logic params_valid,
	input wire logic params_bad,
	input wire logic proc_irq_en,
	input wire logic diag_irq_en,
	input wire logic [CH_NUM-1:0] wire_break_en,
	input wire logic [CH_NUM-1:0] short_en,
	input wire logic [CH_NUM-1:0] rise_en,
	input wire logic [CH_NUM-1:0] fall_en,
	input wire logic [2:0] delay_sel,
	input wire logic load_supply_ok,
	input wire logic cpu_run,
	input wire logic ack_strobe,
	input wire logic [CH_NUM-1:0] ack_mask,
	output logic [CH_NUM-1:0] process_value,
	output logic proc_irq_req,
	output logic [MASK_W-1:0] trigger_channel_mask,
	output logic diag_irq,
	output logic [CH_NUM-1:0] short_fault,
	output logic [CH_NUM-1:0] open_fault,
	output logic [CH_NUM-1:0] irq_lost,
	output logic not_configured,
	output logic bad_params,
	output logic supply_missing,
	output logic group_fault_indicator
);
	// ====================================================================
	// effective enables
	logic proc_en_eff;
	logic diag_en_eff;
	assign proc_en_eff = params_valid & proc_irq_en;
	assign diag_en_eff = params_valid & diag_irq_en;

	// ====================================================================
	// input delay filter, one per channel
	logic [CNT_W-1:0] dly_cyc;
	always_comb begin
		case (ied_dly_type'(delay_sel))
			IED_DLY_0P1: dly_cyc = CNT_W'(DLY_0P1_CYC);
			IED_DLY_0P5: dly_cyc = CNT_W'(DLY_0P5_CYC_P);
			IED_DLY_15: dly_cyc = CNT_W'(DLY_15_CYC_P);
			IED_DLY_20: dly_cyc = CNT_W'(DLY_20_CYC_P);
			default: dly_cyc = CNT_W'(DLY_3_CYC_P);
		endcase
	end

	logic [CH_NUM-1:0] filt_ff;
	logic [CH_NUM-1:0] filt_prev_ff;
	logic [CH_NUM-1:0][CNT_W-1:0] flt_cnt_ff;
	genvar gi;
	generate
		for (gi = 0; gi < CH_NUM; gi++) begin : g_flt
			// a new level is taken only after it stood for the whole delay
			always_ff @(posedge ref_clk) begin
				if (srst) begin
					flt_cnt_ff[gi] <= '0;
					filt_ff[gi] <= 1'b0;
				end else if (raw_in[gi] == filt_ff[gi]) begin
					flt_cnt_ff[gi] <= '0;
				end else if (flt_cnt_ff[gi] >= dly_cyc - CNT_W'(1)) begin
					flt_cnt_ff[gi] <= '0;
					filt_ff[gi] <= raw_in[gi];
				end else begin
					flt_cnt_ff[gi] <= flt_cnt_ff[gi] + CNT_W'(1);
				end
			end
		end
	endgenerate

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			filt_prev_ff <= '0;
		end else begin
			filt_prev_ff <= filt_ff;
		end
	end

	// ====================================================================
	// edge events and pending store
	logic [CH_NUM-1:0] edge_hit;
	logic [CH_NUM-1:0] ack_hit;
	logic [CH_NUM-1:0] pend_ff;
	logic [CH_NUM-1:0] lost_new;
	assign edge_hit = (filt_ff & ~filt_prev_ff & rise_en)
		| (~filt_ff & filt_prev_ff & fall_en);
	assign ack_hit = ack_strobe ? ack_mask : '0;
	// an edge in the acknowledge cycle starts a fresh event instead of being lost
	assign lost_new = edge_hit & pend_ff & ~ack_hit & {CH_NUM{proc_en_eff}};

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			pend_ff <= '0;
		end else begin
			pend_ff <= (pend_ff & ~ack_hit)
				| (edge_hit & {CH_NUM{proc_en_eff}});
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			irq_lost <= '0;
		end else begin
			irq_lost <= (irq_lost & ~ack_hit) | lost_new;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			proc_irq_req <= 1'b0;
			trigger_channel_mask <= '0;
		end else begin
			proc_irq_req <= |pend_ff;
			trigger_channel_mask <= {{(MASK_W-CH_NUM){1'b0}}, pend_ff};
		end
	end

	// ====================================================================
	// fault classification
	logic [CH_NUM-1:0] short_raw;
	logic [CH_NUM-1:0] open_raw;
	generate
		for (gi = 0; gi < CH_NUM; gi++) begin : g_cls
			assign short_raw[gi] = loop_current_ua[gi] > SHORT_UA;
			assign open_raw[gi] = loop_current_ua[gi] <= OPEN_UA;
		end
	endgenerate

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			short_fault <= '0;
			open_fault <= '0;
			not_configured <= 1'b1;
			bad_params <= 1'b0;
			supply_missing <= 1'b0;
		end else begin
			short_fault <= short_raw & short_en;
			open_fault <= open_raw & wire_break_en;
			not_configured <= ~params_valid;
			bad_params <= params_bad;
			supply_missing <= ~load_supply_ok;
		end
	end

	// ====================================================================
	// diagnostic interrupt on any change of the reported fault set
	localparam int DV_W = 2 * CH_NUM + 3;
	logic [DV_W-1:0] diag_vec;
	logic [DV_W-1:0] diag_vec_ff;
	assign diag_vec = {short_raw & short_en, open_raw & wire_break_en,
		~params_valid, params_bad, ~load_supply_ok};

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			diag_vec_ff <= '0;
		end else begin
			diag_vec_ff <= diag_vec;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			diag_irq <= 1'b0;
		end else begin
			diag_irq <= diag_en_eff & ((diag_vec != diag_vec_ff) | (|lost_new));
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			group_fault_indicator <= 1'b0;
		end else begin
			group_fault_indicator <= (|diag_vec) | (|lost_new);
		end
	end

	// ====================================================================
	// load supply hold timer and process values
	logic [CNT_W-1:0] sup_cnt_ff;
	logic sup_expired;
	assign sup_expired = sup_cnt_ff >= CNT_W'(SUPPLY_HOLD_CYC_P);

	always_ff @(posedge ref_clk) begin
		if (srst || load_supply_ok) begin
			sup_cnt_ff <= '0;
		end else if (!sup_expired) begin
			sup_cnt_ff <= sup_cnt_ff + CNT_W'(1);
		end
	end

	// short dips keep the last values; in stop a missing supply zeros at once
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			process_value <= '0;
		end else if (load_supply_ok) begin
			process_value <= filt_ff;
		end else if (sup_expired || !cpu_run) begin
			process_value <= '0;
		end
	end

	// ====================================================================
	// independent age of a supply loss, so the hold span is not judged
	// by the very counter that it is meant to check
	logic [CNT_W-1:0] loss_age_ff;

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			loss_age_ff <= '0;
		end else if (load_supply_ok) begin
			loss_age_ff <= '0;
		end else if (loss_age_ff != {CNT_W{1'b1}}) begin
			loss_age_ff <= loss_age_ff + CNT_W'(1);
		end
	end

	// ====================================================================
	// checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst);

	// an event already pending before the parameters went away may still stand
	AST_UNCONF_QUIET: assert property (!params_valid && pend_ff == '0
		|=> !diag_irq ##1 !proc_irq_req)
		else $error("interrupt raised while unconfigured");
	AST_DIAG_CHANGE: assert property (diag_en_eff && diag_vec != diag_vec_ff |=> diag_irq)
		else $error("fault change without diagnostic interrupt");
	AST_MASKED_OPEN: assert property (wire_break_en == '0 |=> open_fault == '0)
		else $error("disabled open check reported");
	AST_SHORT_TH: assert property (short_en[0] && loop_current_ua[0] > SHORT_UA
		|=> short_fault[0])
		else $error("short not flagged");
	AST_OPEN_TH: assert property (wire_break_en[0] && loop_current_ua[0] <= OPEN_UA
		|=> open_fault[0] && !short_fault[0])
		else $error("open not flagged");
	AST_UNCONF_FLAG: assert property (!params_valid |=> not_configured)
		else $error("unconfigured not reported");
	AST_EDGE_PEND: assert property (edge_hit[0] && proc_en_eff |=> pend_ff[0] ##1 proc_irq_req
		&& trigger_channel_mask[0])
		else $error("edge not recorded");
	AST_LOST: assert property (lost_new[0] |=> irq_lost[0] && pend_ff[0])
		else $error("lost event not flagged");
	AST_ACK: assert property (ack_strobe && ack_mask[1] && !edge_hit[1] |=> !pend_ff[1])
		else $error("ack did not clear pending");
	AST_DIP_HOLD: assert property ($fell(load_supply_ok) && cpu_run |=> $stable(process_value))
		else $error("dip changed process values");
	AST_SUP_ZERO: assert property (!load_supply_ok && sup_expired |=> process_value == '0)
		else $error("values not zeroed after hold");
	AST_SUP_FAULT: assert property (!load_supply_ok |=> supply_missing ##0 group_fault_indicator)
		else $error("supply loss not indicated");

	AST_RESET_STATE: assert property (disable iff (1'b0) srst
		|=> not_configured && !proc_irq_req && !diag_irq && process_value == '0)
		else $error("outputs not at reset values");

	AST_BAD_FLAG: assert property (params_bad |=> bad_params)
		else $error("bad parameters not reported");

	AST_BAD_CLEAR: assert property (!params_bad |=> !bad_params)
		else $error("bad parameters reported without cause");

	AST_RISE_ONLY: assert property (filt_ff[0] && !filt_prev_ff[0] && !rise_en[0]
		|-> !edge_hit[0])
		else $error("rising edge taken while disabled");

	AST_FALL_ONLY: assert property (!filt_ff[0] && filt_prev_ff[0] && !fall_en[0]
		|-> !edge_hit[0])
		else $error("falling edge taken while disabled");

	AST_FALL_EVENT: assert property (!filt_ff[1] && filt_prev_ff[1] && fall_en[1]
		|-> edge_hit[1])
		else $error("enabled falling edge missed");

	AST_NO_EDGE_STEADY: assert property (filt_ff == filt_prev_ff |-> edge_hit == '0)
		else $error("edge seen on steady filtered input");

	AST_PEND_KEEP: assert property (pend_ff[1] && !(ack_strobe && ack_mask[1])
		|=> pend_ff[1])
		else $error("pending event dropped without ack");

	AST_PROC_OFF: assert property (!proc_en_eff && pend_ff == '0 |=> pend_ff == '0)
		else $error("event recorded while disabled");

	AST_REQ_FOLLOWS: assert property (1'b1 |=> proc_irq_req == (|$past(pend_ff)))
		else $error("request does not follow pending store");

	AST_MASK_HIGH: assert property (trigger_channel_mask[MASK_W-1:CH_NUM] == '0)
		else $error("mask bits above the channels set");

	AST_LOST_CLEAR: assert property (ack_strobe && ack_mask[1] |=> !irq_lost[1])
		else $error("ack did not clear lost flag");

	AST_LIVE: assert property (load_supply_ok |=> process_value == $past(filt_ff))
		else $error("live value not delivered");

	AST_STOP_ZERO: assert property (!load_supply_ok && !cpu_run |=> process_value == '0)
		else $error("stop without supply not zero");

	AST_HOLD_SPAN: assert property (cpu_run && !load_supply_ok
		&& loss_age_ff < CNT_W'(SUPPLY_HOLD_CYC_P) |=> $stable(process_value))
		else $error("value not held during supply loss");

	AST_HOLD_END: assert property (!load_supply_ok
		&& loss_age_ff >= CNT_W'(SUPPLY_HOLD_CYC_P) |=> process_value == '0)
		else $error("value not zero after hold span");

	AST_SUP_COUNT: assert property (!load_supply_ok && !sup_expired
		|=> sup_cnt_ff == $past(sup_cnt_ff) + CNT_W'(1))
		else $error("supply timer stalled");

	AST_DIP_DIAG: assert property (diag_en_eff && $changed(load_supply_ok) && !$past(srst)
		|=> diag_irq)
		else $error("supply dip not diagnosed");

	AST_GFI_DIAG: assert property (diag_vec != '0 |=> group_fault_indicator)
		else $error("fault without group indicator");

	AST_DIAG_MASKED: assert property (!diag_en_eff |=> !diag_irq)
		else $error("diagnostic interrupt while disabled");

	AST_DIAG_QUIET: assert property (diag_vec == diag_vec_ff && lost_new == '0
		|=> !diag_irq)
		else $error("diagnostic interrupt without cause");

	AST_FILT_HOLD: assert property (raw_in[0] != filt_ff[0]
		&& flt_cnt_ff[0] < dly_cyc - CNT_W'(1) |=> $stable(filt_ff[0]))
		else $error("filter passed a short level");

	AST_FILT_TAKE: assert property (raw_in[0] != filt_ff[0]
		&& flt_cnt_ff[0] >= dly_cyc - CNT_W'(1) |=> filt_ff[0] == $past(raw_in[0]))
		else $error("filter did not take a settled level");

	COV_EDGE_ACK: cover property (pend_ff[0] ##[1:20] ack_strobe && ack_mask[0]);
	COV_LOST: cover property (lost_new != '0);
	COV_SUP_EXPIRE: cover property (!load_supply_ok && sup_expired);
	COV_FALL_EVENT: cover property (edge_hit[1] && fall_en[1] && !filt_ff[1]);
	COV_DIP: cover property (!load_supply_ok && !sup_expired ##1 load_supply_ok);
endmodule : ied_top
`default_nettype wire

//--- ied_host_model.sv
// host model that services process events by acknowledging them
// assumes ack is sampled by the block on the rising edge of ref_clk
`timescale 1ns/1ps
`default_nettype none
module ied_host_model
	import ied_pkg::*;
(
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic hold,
	input wire logic proc_irq_req,
	input wire logic [MASK_W-1:0] trigger_channel_mask,
	output logic ack_strobe,
	output logic [CH_NUM-1:0] ack_mask
);
	// ====================================================
	// acknowledge loop
	initial begin
		ack_strobe = 1'h0;
		ack_mask = 4'h0;
		forever begin
			@(negedge ref_clk);
			if (!srst && !hold && proc_irq_req === 1'h1) begin
				ack_mask = trigger_channel_mask[CH_NUM-1:0];
				ack_strobe = 1'h1;
				@(negedge ref_clk);
				ack_strobe = 1'h0;
				ack_mask = ~ack_mask;
				// let the request fall before looking again
				repeat (3) @(negedge ref_clk);
			end else begin
				// idle mask changes every cycle so a stale mask never looks valid
				ack_mask = ~ack_mask;
			end
		end
	end
endmodule : ied_host_model
`default_nettype wire

//--- tb.sv
// self-checking bench for the input event and diagnostic block
// assumes ied_host_model answers events when hold is low
`timescale 1ns/1ps
`default_nettype none
module tb;
	import ied_pkg::*;
	logic ref_clk = 1'h0;
	logic srst = 1'h1;
	logic [CH_NUM-1:0] raw = 4'h0, wbe = 4'h0, she = 4'h0, re = 4'h0, fe = 4'h0;
	logic [CH_NUM-1:0][CUR_W-1:0] cur = {4{16'h0800}};
	logic pv = 1'h0, pb = 1'h0, pe = 1'h1, de = 1'h1, ld = 1'h1, run = 1'h1, hold = 1'h1;
	logic [2:0] dsel = 3'h7;
	logic ack, preq, dirq, nc, bp, sm, gfi;
	logic [CH_NUM-1:0] am, pval, sf, of, lost;
	logic [MASK_W-1:0] tmask;
	int n_errors = 0;
	int samples_checked = 0;
	int nd = 0;
	int k;
	ied_top #(.DLY_0P5_CYC_P(8), .DLY_3_CYC_P(12), .DLY_15_CYC_P(16), .DLY_20_CYC_P(20),
		.SUPPLY_HOLD_CYC_P(30)) uut (.ref_clk(ref_clk), .srst(srst), .raw_in(raw),
		.loop_current_ua(cur), .params_valid(pv), .params_bad(pb), .proc_irq_en(pe),
		.diag_irq_en(de), .wire_break_en(wbe), .short_en(she), .rise_en(re), .fall_en(fe),
		.delay_sel(dsel), .load_supply_ok(ld), .cpu_run(run), .ack_strobe(ack),
		.ack_mask(am), .process_value(pval), .proc_irq_req(preq),
		.trigger_channel_mask(tmask), .diag_irq(dirq), .short_fault(sf), .open_fault(of),
		.irq_lost(lost), .not_configured(nc), .bad_params(bp), .supply_missing(sm),
		.group_fault_indicator(gfi));
	ied_host_model host (.ref_clk(ref_clk), .srst(srst), .hold(hold), .proc_irq_req(preq),
		.trigger_channel_mask(tmask), .ack_strobe(ack), .ack_mask(am));
	// ====================================================
	// clock, pulse count, helpers
	initial forever #20 ref_clk = ~ref_clk;
	always @(posedge ref_clk) if (dirq === 1'h1) nd <= nd + 1;
	task automatic cy(input int n);
		repeat (n) @(negedge ref_clk);
	endtask : cy
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (e !== g) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", s, e, g);
		end
	endtask : chk
	task automatic conclude();
		$display("checks %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : conclude
	// ====================================================
	// scenarios
	task automatic t_unconf();
		chk("not_configured", 1, nc);
		re = 4'h1;
		raw = 4'h1;
		cy(20);
		chk("proc_irq_req", 0, preq);
		raw = 4'h0;
		cy(20);
		pv = 1'h1;
		cy(3);
		chk("not_configured", 0, nc);
		$display("t_unconf done");
	endtask : t_unconf
	task automatic t_edge();
		dsel = 3'h2;
		raw = 4'h1;
		cy(20);
		chk("mask", 32'h1, tmask);
		chk("proc_irq_req", 1, preq);
		hold = 1'h0;
		cy(6);
		chk("proc_irq_req", 0, preq);
		hold = 1'h1;
		raw = 4'h0;
		cy(20);
		chk("proc_irq_req", 0, preq);
		$display("t_edge done");
	endtask : t_edge
	task automatic t_lost();
		dsel = 3'h1;
		re = 4'h2;
		fe = 4'h2;
		raw = 4'h2;
		cy(20);
		k = nd;
		raw = 4'h0;
		cy(20);
		chk("irq_lost", 4'h2, lost);
		chk("diag count", k + 1, nd);
		chk("mask", 32'h2, tmask);
		hold = 1'h0;
		cy(6);
		chk("irq_lost", 4'h0, lost);
		chk("proc_irq_req", 0, preq);
		hold = 1'h1;
		$display("t_lost done");
	endtask : t_lost
	task automatic t_fault();
		k = nd;
		cur[3] = 16'h0064;
		cy(4);
		chk("open_fault", 4'h0, of);
		chk("diag count", k, nd);
		cur[3] = 16'h0065;
		wbe[3] = 1'h1;
		cy(4);
		chk("open_fault", 4'h0, of);
		cur[3] = 16'h0064;
		cy(4);
		chk("open_fault", 4'h8, of);
		chk("diag count", k + 1, nd);
		cur[3] = 16'h0800;
		she[2] = 1'h1;
		cur[2] = 16'h2134;
		cy(4);
		chk("diag count", k + 2, nd);
		chk("short_fault", 4'h0, sf);
		cur[2] = 16'h2135;
		cy(4);
		chk("short_fault", 4'h4, sf);
		cur[2] = 16'h0800;
		pb = 1'h1;
		cy(3);
		chk("bad_params", 1, bp);
		pb = 1'h0;
		$display("t_fault done");
	endtask : t_fault
	task automatic t_supply();
		re = 4'h0;
		fe = 4'h0;
		raw = 4'h1;
		cy(20);
		chk("process_value", 4'h1, pval);
		k = nd;
		ld = 1'h0;
		cy(10);
		chk("process_value", 4'h1, pval);
		chk("supply_missing", 1, sm);
		chk("group_fault", 1, gfi);
		chk("diag seen", 1, nd > k);
		ld = 1'h1;
		cy(3);
		ld = 1'h0;
		cy(25);
		chk("process_value", 4'h1, pval);
		cy(10);
		chk("process_value", 4'h0, pval);
		ld = 1'h1;
		cy(3);
		chk("process_value", 4'h1, pval);
		run = 1'h0;
		ld = 1'h0;
		cy(3);
		chk("process_value", 4'h0, pval);
		$display("t_supply done");
	endtask : t_supply
	// ====================================================
	// main sequence and watchdog
	initial begin
		cy(12);
		srst = 1'h0;
		cy(2);
		t_unconf();
		t_edge();
		t_lost();
		t_fault();
		t_supply();
		conclude();
	end
	initial begin
		// the tests need about 250 cycles
		repeat (2000) @(posedge ref_clk);
		n_errors++;
		conclude();
	end
endmodule : tb
`default_nettype wire
